//--- src/ctes_top.v
// Camera trigger, exposure, shutter, scan and strobe controller top
// Function
// - Trigger accepted only while capture is stopped
// - Mode 0 edge select, frame rate sets length except with both edges
// - Mode 1 integrates during low trigger pulse
// - Rising option starts on rising edge
// - Falling option starts on falling edge
// - Both edges: fall to rise, deliver after
// - Partial scan reads only whole lines
// - Draft mode cuts lines 659 to 240
// - Factory reset replaces stored settings later
// - Forty second storage init after factory reset
// - Writable identification number reported as identity
// - Brightness setting moves black level
// - Gain setting, minimum gives lowest noise
// - Clearing pulses early, then integrate to end
// - Four strobes with own start and stop
// - Disabled strobe stays inactive once out of reset
// - Per-strobe polarity select
// - Strobe times counted from vertical interval
`timescale 1ns/1ps
`include "ctes_defines.vh"
module ctes_top #(
   parameter CW          = 24,
   parameter NS          = 4,
   parameter NV_INIT_CYC = `CTES_NV_INIT_CYC
) (
   input  wire             sys_clk,
   input  wire             rst_b,
   input  wire             capture_run,
   input  wire             trig_enable,
   input  wire             trig_in,
   input  wire             trig_mode,
   input  wire [1:0]       edge_sel,
   input  wire [CW-1:0]    frame_period,
   input  wire [CW-1:0]    shutter_clear,
   input  wire             draft_en,
   input  wire             partial_en,
   input  wire [10:0]      partial_top,
   input  wire [10:0]      partial_height,
   input  wire             factory_reset,
   input  wire             nv_loaded,
   input  wire             id_wr,
   input  wire [31:0]      id_wdata,
   input  wire [7:0]       bright_in,
   input  wire [7:0]       gain_in,
   input  wire             bg_wr,
   input  wire [NS-1:0]    strb_en,
   input  wire [NS-1:0]    strb_pol,
   input  wire [NS*CW-1:0] strb_start,
   input  wire [NS*CW-1:0] strb_stop,
   output reg              vsync_r,
   output reg              clear_pulse_r,
   output reg              integrating_r,
   output reg              image_ready_r,
   output reg  [10:0]      lines_per_frame_r,
   output reg  [10:0]      first_line_r,
   output reg  [10:0]      line_width_r,
   output reg              nv_restore_r,
   output reg              nv_busy_r,
   output reg              ready_r,
   output reg  [31:0]      dev_id_r,
   output reg  [7:0]       black_level_r,
   output reg  [7:0]       gain_r,
   output wire [NS-1:0]    strobe_out
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_CLEAR = 2'd1;
   localparam ST_INTEG = 2'd2;
   localparam ST_DONE  = 2'd3;

   reg           rst_m_r;
   reg           rst_s_r;
   wire          rst_n;
   wire          trig_rise;
   wire          trig_fall;
   reg  [1:0]    state_r;
   reg  [1:0]    state_nxt;
   reg  [CW-1:0] frame_cnt_r;
   reg  [CW-1:0] frame_cnt_nxt;
   reg           pulse_mode_r;
   reg           pulse_mode_nxt;
   reg           fr_vsync;
   reg           start_ev;
   reg           end_ev;
   reg  [31:0]   nv_cnt_r;
   wire          trig_armed;
   wire          end_of_frame;

   //////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_s_r <= rst_m_r;
      end
   end
   assign rst_n = rst_s_r;

   //////////////////////////////////////////////////////////////////////
   // Trigger pin synchroniser and edge detector
   ctes_edge_sync u_trig (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (trig_in),
      .level    (),
      .rise     (trig_rise),
      .fall     (trig_fall)
   );

   // Trigger is armed only while continuous capture is stopped
   assign trig_armed = trig_enable & ~capture_run;
   assign end_of_frame = (frame_cnt_r >= frame_period - 1'b1);

   // Start event selection by trigger mode and edge option
   always @* begin
      start_ev       = 1'b0;
      pulse_mode_nxt = pulse_mode_r;
      if (capture_run) begin
         start_ev       = (state_r == ST_IDLE);
         pulse_mode_nxt = 1'b0;
      end else if (trig_armed && state_r == ST_IDLE) begin
         if (trig_mode == `CTES_TMODE_PULSE) begin
            start_ev       = trig_fall;
            pulse_mode_nxt = 1'b1;
         end else begin
            case (edge_sel)
               `CTES_EDGE_RISE: begin
                  start_ev       = trig_rise;
                  pulse_mode_nxt = 1'b0;
               end
               `CTES_EDGE_FALL: begin
                  start_ev       = trig_fall;
                  pulse_mode_nxt = 1'b0;
               end
               `CTES_EDGE_BOTH: begin
                  start_ev       = trig_fall;
                  pulse_mode_nxt = 1'b1;
               end
               default: begin
                  start_ev       = 1'b0;
                  pulse_mode_nxt = 1'b0;
               end
            endcase
         end
      end
   end

   // End of integration: next rising edge in pulse modes, else frame end
   always @* begin
      if (pulse_mode_r)
         end_ev = trig_rise;
      else
         end_ev = end_of_frame;
   end

   //////////////////////////////////////////////////////////////////////
   // Exposure state machine
   always @* begin
      state_nxt     = state_r;
      frame_cnt_nxt = frame_cnt_r + 1'b1;
      fr_vsync      = 1'b0;
      case (state_r)
         ST_IDLE: begin
            frame_cnt_nxt = {CW{1'b0}};
            if (start_ev) begin
               fr_vsync  = 1'b1;
               // Pulse modes take exposure from the pin, no clearing
               if (shutter_clear != {CW{1'b0}} && !pulse_mode_nxt)
                  state_nxt = ST_CLEAR;
               else
                  state_nxt = ST_INTEG;
            end
         end
         ST_CLEAR: begin
            // Clearing pulses early in the frame, then integrate
            if (frame_cnt_r >= shutter_clear - 1'b1)
               state_nxt = ST_INTEG;
            if (end_of_frame)
               state_nxt = ST_DONE;
         end
         ST_INTEG: begin
            if (end_ev)
               state_nxt = ST_DONE;
         end
         ST_DONE: begin
            state_nxt     = ST_IDLE;
            frame_cnt_nxt = {CW{1'b0}};
         end
         default: begin
            state_nxt     = ST_IDLE;
            frame_cnt_nxt = {CW{1'b0}};
         end
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r       <= ST_IDLE;
         frame_cnt_r   <= {CW{1'b0}};
         pulse_mode_r  <= 1'b0;
         vsync_r       <= 1'b0;
         clear_pulse_r <= 1'b0;
         integrating_r <= 1'b0;
         image_ready_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         frame_cnt_r   <= frame_cnt_nxt;
         if (state_r == ST_IDLE)
            pulse_mode_r <= pulse_mode_nxt;
         vsync_r       <= fr_vsync;
         clear_pulse_r <= (state_nxt == ST_CLEAR);
         integrating_r <= (state_nxt == ST_INTEG);
         // Image is handed on only after the frame or rising edge ends it
         image_ready_r <= (state_r == ST_INTEG || state_r == ST_CLEAR) &&
                          (state_nxt == ST_DONE);
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Scan geometry: whole lines only, width never narrowed
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lines_per_frame_r <= `CTES_LINES_FULL;
         first_line_r      <= 11'h000;
         line_width_r      <= `CTES_LINE_WIDTH;
      end else begin
         line_width_r <= `CTES_LINE_WIDTH;
         if (draft_en) begin
            lines_per_frame_r <= `CTES_LINES_DRAFT;
            first_line_r      <= 11'h000;
         end else if (partial_en && partial_height != 11'h000 &&
                      {1'b0, partial_top} + {1'b0, partial_height} <=
                      {1'b0, `CTES_LINES_FULL}) begin
            lines_per_frame_r <= partial_height;
            first_line_r      <= partial_top;
         end else begin
            lines_per_frame_r <= `CTES_LINES_FULL;
            first_line_r      <= 11'h000;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Factory restore and storage reinitialisation after power-up
   // Restore is only requested here; new values apply after power cycle
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_restore_r <= 1'b0;
         nv_busy_r    <= 1'b0;
         ready_r      <= 1'b0;
         nv_cnt_r     <= 32'h00000000;
      end else begin
         nv_restore_r <= factory_reset;
         // Power-up after a restore: hold off for the full init time
         if (nv_loaded && !nv_busy_r && !ready_r) begin
            nv_busy_r <= 1'b1;
            nv_cnt_r  <= 32'h00000000;
         end else if (nv_busy_r) begin
            if (nv_cnt_r >= NV_INIT_CYC - 1) begin
               nv_busy_r <= 1'b0;
               ready_r   <= 1'b1;
            end else begin
               nv_cnt_r <= nv_cnt_r + 32'h00000001;
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Identity and analog settings
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_id_r      <= `CTES_ID_RESET;
         black_level_r <= `CTES_BRIGHT_RESET;
         gain_r        <= `CTES_GAIN_RESET;
      end else begin
         if (id_wr)
            dev_id_r <= id_wdata;
         if (bg_wr) begin
            black_level_r <= bright_in;
            gain_r        <= gain_in;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Strobe channels; host keeps windows inside integration time
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi = gi + 1) begin : g_strb
         ctes_strobe #(
            .CW (CW)
         ) u_strb (
            .sys_clk     (sys_clk),
            .rst_n       (rst_n),
            .frame_cnt   (frame_cnt_r),
            .enable      (strb_en[gi] & (state_r != ST_IDLE)),
            .active_high (strb_pol[gi]),
            .start_pt    (strb_start[gi*CW +: CW]),
            .stop_pt     (strb_stop[gi*CW +: CW]),
            .strobe_out  (strobe_out[gi])
         );
      end
   endgenerate
endmodule

//--- src/ctes_defines.vh
// Shared constants for the camera trigger, exposure and strobe controller
`ifndef CTES_DEFINES_VH
`define CTES_DEFINES_VH
`define CTES_TMODE_EDGE      1'b0
`define CTES_TMODE_PULSE     1'b1
`define CTES_EDGE_RISE       2'd0
`define CTES_EDGE_FALL       2'd1
`define CTES_EDGE_BOTH       2'd2
`define CTES_LINES_FULL      11'd659
`define CTES_LINES_DRAFT     11'd240
`define CTES_LINE_WIDTH      11'd494
`define CTES_CLK_HZ          20000000
`define CTES_NV_INIT_SEC     40
`define CTES_NV_INIT_CYC     (`CTES_NV_INIT_SEC * `CTES_CLK_HZ)
`define CTES_ID_RESET        32'h00000001
`define CTES_NUM_STROBES     4
`define CTES_BRIGHT_RESET    8'h80
`define CTES_GAIN_RESET      8'h00
`endif

//--- src/ctes_edge_sync.v
// Two-flop synchroniser with rise and fall detection on the clean copy
`timescale 1ns/1ps
module ctes_edge_sync (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire async_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_r;
   reg sync_r;
   reg prev_r;

   // Only sync_r reads meta_r; edges come from sync_r and prev_r
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
   assign fall  = ~sync_r & prev_r;
endmodule

//--- src/ctes_strobe.v
// One strobe channel: window compare with enable and polarity
`timescale 1ns/1ps
module ctes_strobe #(
   parameter CW = 24
) (
   input  wire          sys_clk,
   input  wire          rst_n,
   input  wire [CW-1:0] frame_cnt,
   input  wire          enable,
   input  wire          active_high,
   input  wire [CW-1:0] start_pt,
   input  wire [CW-1:0] stop_pt,
   output reg           strobe_out
);
   wire in_win;

   // Window counted from vertical interval start, stop is exclusive
   assign in_win = (frame_cnt >= start_pt) &&
                   (frame_cnt < stop_pt);

   // Out of reset, a disabled channel holds its inactive level whatever the window says
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         strobe_out <= 1'b0;
      else
         strobe_out <= (enable & in_win) ?
                       active_high : ~active_high;
   end
endmodule

//--- bench/ctes_sva.sv
// Port-level checker for the trigger, exposure and strobe controller
`timescale 1ns/1ps
module ctes_sva #(
   parameter CW          = 24,
   parameter NS          = 4,
   parameter NV_INIT_CYC = 20
) (
   input wire          sys_clk,
   input wire          rst_b,
   input wire          capture_run,
   input wire          trig_enable,
   input wire          draft_en,
   input wire          factory_reset,
   input wire          id_wr,
   input wire [31:0]   id_wdata,
   input wire          bg_wr,
   input wire [7:0]    bright_in,
   input wire [7:0]    gain_in,
   input wire [NS-1:0] strb_en,
   input wire [NS-1:0] strb_pol,
   input wire          vsync_r,
   input wire          clear_pulse_r,
   input wire          integrating_r,
   input wire          image_ready_r,
   input wire [10:0]   lines_per_frame_r,
   input wire [10:0]   line_width_r,
   input wire          nv_restore_r,
   input wire          nv_busy_r,
   input wire          ready_r,
   input wire [31:0]   dev_id_r,
   input wire [7:0]    black_level_r,
   input wire [7:0]    gain_r,
   input wire [NS-1:0] strobe_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   // Settle counter: internal reset lags the pin, so skip the first edges
   logic [2:0]  up_cnt_r;
   logic [31:0] busy_cnt_r;
   wire         up = (up_cnt_r == 3'h7);
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         up_cnt_r   <= 3'h0;
         busy_cnt_r <= 32'h0;
      end else begin
         if (!up) up_cnt_r <= up_cnt_r + 3'h1;
         busy_cnt_r <= nv_busy_r ? busy_cnt_r + 32'h1 : 32'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_width; line_width_r == 11'd494; endproperty
   a_width: assert property (p_width)
      else $error("line width wrong");
   property p_draft;
      (up && draft_en)[*4] |-> lines_per_frame_r == 11'd240;
   endproperty
   a_draft: assert property (p_draft)
      else $error("draft lines wrong");
   property p_no_trig;
      (up && !capture_run && !trig_enable)[*4] |-> !vsync_r;
   endproperty
   a_no_trig: assert property (p_no_trig)
      else $error("frame unarmed");
   property p_excl; !(clear_pulse_r && integrating_r); endproperty
   a_excl: assert property (p_excl)
      else $error("clear overlaps");
   property p_start; up && $rose(vsync_r) |-> integrating_r || clear_pulse_r;
   endproperty
   a_start: assert property (p_start)
      else $error("no exposure");
   property p_end;
      up && $rose(image_ready_r) |-> $past(integrating_r) && !integrating_r;
   endproperty
   a_end: assert property (p_end)
      else $error("end mistimed");
   property p_restore; up && factory_reset |=> nv_restore_r; endproperty
   a_restore: assert property (p_restore)
      else $error("no restore");
   property p_id; up && id_wr |=> dev_id_r == $past(id_wdata); endproperty
   a_id: assert property (p_id)
      else $error("id not taken");
   property p_bg;
      up && bg_wr |=> black_level_r == $past(bright_in) &&
                      gain_r == $past(gain_in);
   endproperty
   a_bg: assert property (p_bg)
      else $error("level wrong");
   property p_strb_off;
      (up && strb_en == {NS{1'b0}})[*3] |-> strobe_out == ~$past(strb_pol);
   endproperty
   a_strb_off: assert property (p_strb_off)
      else $error("strobe on");
   property p_nv_len;
      $fell(nv_busy_r) |-> ready_r && busy_cnt_r >= NV_INIT_CYC;
   endproperty
   a_nv_len: assert property (p_nv_len)
      else $error("init short");
   c_clear: cover property ($rose(clear_pulse_r));
   c_frame: cover property ($rose(image_ready_r));
   c_nv:    cover property ($fell(nv_busy_r));
endmodule
bind ctes_top ctes_sva #(.CW(CW), .NS(NS), .NV_INIT_CYC(NV_INIT_CYC)) i_ctes_sva (
   .sys_clk(sys_clk), .rst_b(rst_b), .capture_run(capture_run),
   .trig_enable(trig_enable), .draft_en(draft_en), .id_wr(id_wr),
   .factory_reset(factory_reset), .id_wdata(id_wdata), .bg_wr(bg_wr),
   .bright_in(bright_in), .gain_in(gain_in), .strb_en(strb_en),
   .strb_pol(strb_pol), .vsync_r(vsync_r), .clear_pulse_r(clear_pulse_r),
   .integrating_r(integrating_r), .image_ready_r(image_ready_r),
   .lines_per_frame_r(lines_per_frame_r), .line_width_r(line_width_r),
   .nv_restore_r(nv_restore_r), .nv_busy_r(nv_busy_r), .ready_r(ready_r),
   .dev_id_r(dev_id_r), .black_level_r(black_level_r), .gain_r(gain_r),
   .strobe_out(strobe_out));

//--- bench/ctes_partner.sv
// External trigger source: idle level plus one pulse of set width
`timescale 1ns/1ps
module ctes_partner (
   input  wire       sys_clk,
   input  wire       fire,
   input  wire       idle_hi,
   input  wire [7:0] width,
   output reg        trig_in
);
   // Idle high matches the synchroniser reset level, so no false edge
   initial trig_in = 1'b1;
   // Pin moves 13 ns after the edge, so the device must resynchronise it
   always @(posedge sys_clk) begin
      if (fire) begin
         #13 trig_in = ~idle_hi;
         repeat (width) @(posedge sys_clk);
         #13 trig_in = idle_hi;
      end else begin
         #13 trig_in = idle_hi;
      end
   end
endmodule

//--- bench/ctes_bench.sv
// Self-checking bench for the trigger, exposure and strobe controller
`timescale 1ns/1ps
module ctes_bench;
   reg         sys_clk = 1'b0, rst_b = 1'b0, trig_enable = 1'b0;
   reg         trig_mode = 1'b0, draft_en = 1'b0, partial_en = 1'b0;
   reg         factory_reset = 1'b0, nv_loaded = 1'b0, id_wr = 1'b0;
   reg         bg_wr = 1'b0, fire = 1'b0, idle_hi = 1'b1, capture_run = 1'b0;
   reg  [1:0]  edge_sel = 2'h0;
   reg  [23:0] shutter_clear = 24'h0;
   reg  [10:0] partial_top = 11'h0, partial_height = 11'h0;
   reg  [31:0] id_wdata = 32'h0;
   reg  [7:0]  bright_in = 8'h0, gain_in = 8'h0, width = 8'h0;
   reg  [3:0]  strb_en = 4'h0;
   reg  [95:0] strb_start, strb_stop;
   wire        trig_in, vsync_r, clear_pulse_r, integrating_r, image_ready_r;
   wire        nv_restore_r, nv_busy_r, ready_r;
   wire [10:0] lines_per_frame_r, first_line_r, line_width_r;
   wire [31:0] dev_id_r;
   wire [7:0]  black_level_r, gain_r;
   wire [3:0]  strobe_out;
   integer     n_fail = 0, compares = 0, cyc = 0, k, i;
   ctes_partner i_ctes_partner (.sys_clk(sys_clk), .fire(fire),
      .idle_hi(idle_hi), .width(width), .trig_in(trig_in));
   ctes_top #(.NV_INIT_CYC(20)) i_ctes_top (.sys_clk(sys_clk), .rst_b(rst_b),
      .capture_run(capture_run), .trig_enable(trig_enable), .trig_in(trig_in),
      .trig_mode(trig_mode), .edge_sel(edge_sel), .frame_period(24'd40),
      .shutter_clear(shutter_clear), .draft_en(draft_en),
      .partial_en(partial_en), .partial_top(partial_top),
      .partial_height(partial_height), .factory_reset(factory_reset),
      .nv_loaded(nv_loaded), .id_wr(id_wr), .id_wdata(id_wdata),
      .bright_in(bright_in), .gain_in(gain_in), .bg_wr(bg_wr),
      .strb_en(strb_en), .strb_pol(4'h5), .strb_start(strb_start),
      .strb_stop(strb_stop), .vsync_r(vsync_r), .clear_pulse_r(clear_pulse_r),
      .integrating_r(integrating_r), .image_ready_r(image_ready_r),
      .lines_per_frame_r(lines_per_frame_r), .first_line_r(first_line_r),
      .line_width_r(line_width_r), .nv_restore_r(nv_restore_r),
      .nv_busy_r(nv_busy_r), .ready_r(ready_r), .dev_id_r(dev_id_r),
      .black_level_r(black_level_r), .gain_r(gain_r), .strobe_out(strobe_out));
   initial forever #25 sys_clk = ~sys_clk;
   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task tick(input integer n); repeat (n) @(posedge sys_clk); endtask
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // Scan geometry is sampled mid-cycle once the registers have settled
   task geo(input d, input p, input [10:0] t, input [10:0] h, input [10:0] xl);
      begin
         draft_en <= d; partial_en <= p; partial_top <= t; partial_height <= h;
         tick(4); @(negedge sys_clk);
         chk("lines", xl, lines_per_frame_r);
         chk("first", (p && !d && xl != 11'd659) ? t : 11'h0, first_line_r);
      end
   endtask
   // One triggered frame; counts clear, exposure and strobe-active cycles
   task frame(input m, input [1:0] es, input ih, input [7:0] w,
              input [23:0] sh, input [3:0] en,
              input [31:0] xc, input [31:0] xi);
      integer nc, ni, s[0:3];
      begin
         trig_enable <= 1'b0; trig_mode <= m; edge_sel <= es; idle_hi <= ih;
         shutter_clear <= sh; strb_en <= en; width <= w;
         tick(6); trig_enable <= 1'b1; tick(2); fire <= 1'b1; tick(1);
         fire <= 1'b0;
         k = 0; nc = 0; ni = 0; s = '{0, 0, 0, 0};
         while (vsync_r !== 1'b1 && k < 20) begin
            @(negedge sys_clk);
            k = k + 1;
         end
         chk("vsync", 32'h1, {31'h0, k < 20});
         k = 0;
         while (image_ready_r !== 1'b1 && k < 300) begin
            nc = nc + clear_pulse_r; ni = ni + integrating_r;
            // Polarity 0101: even channels active high, odd active low
            for (i = 0; i < 4; i = i + 1)
               s[i] = s[i] + (strobe_out[i] === ~i[0]);
            @(negedge sys_clk); k = k + 1;
         end
         chk("clear", xc, nc); chk("integ", xi, ni);
         for (i = 0; i < 4; i = i + 1) chk("strobe", en[i] ? 6 : 0, s[i]);
         tick(w + 4);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      // Strobe windows sit after the clearing period of 4 cycles
      for (i = 0; i < 4; i = i + 1) begin
         strb_start[i*24+:24] = 24'd4 + 3 * i;
         strb_stop[i*24+:24]  = 24'd10 + 3 * i;
      end
      tick(16); @(negedge sys_clk);
      chk("width", 11'd494, line_width_r);
      chk("lines", 11'd659, lines_per_frame_r);
      tick(1); rst_b <= 1'b1; tick(8);
      nv_loaded <= 1'b1; k = 0; tick(1);
      while (ready_r !== 1'b1 && k < 100) begin
         @(negedge sys_clk);
         k = k + nv_busy_r;
      end
      chk("busy", 20, k);
      tick(1); id_wdata <= 32'h5a5a1234; id_wr <= 1'b1;
      bright_in <= 8'h3c; gain_in <= 8'hff; bg_wr <= 1'b1;
      tick(1); id_wr <= 1'b0; bg_wr <= 1'b0; tick(2);
      chk("id", 32'h5a5a1234, dev_id_r);
      chk("black", 8'h3c, black_level_r);
      chk("gain", 8'hff, gain_r);
      geo(0, 1, 11'd10, 11'd100, 11'd100);
      geo(1, 1, 11'd10, 11'd100, 11'd240);
      geo(0, 1, 11'd600, 11'd100, 11'd659);
      geo(0, 0, 11'd0, 11'd0, 11'd659);
      trig_enable <= 1'b0; idle_hi <= 1'b1; fire <= 1'b1; width <= 8'd5;
      tick(1); fire <= 1'b0; k = 0;
      repeat (30) begin @(negedge sys_clk); k = k + vsync_r; end
      chk("unarmed", 0, k);
      frame(0, 2'd0, 0, 8'd5, 24'd0, 4'h0, 0, 40);
      frame(0, 2'd1, 1, 8'd5, 24'd4, 4'h7, 4, 36);
      frame(0, 2'd2, 1, 8'd25, 24'd0, 4'h0, 0, 25);
      frame(1, 2'd3, 1, 8'd30, 24'd4, 4'h0, 0, 30);
      // Free run: pulse trigger ignored, each 42-cycle frame integrates 40
      capture_run <= 1'b1; trig_enable <= 1'b1; trig_mode <= 1'b1;
      shutter_clear <= 24'h0; tick(50); fire <= 1'b1; width <= 8'd5;
      tick(1); fire <= 1'b0; k = 0;
      repeat (84) begin @(negedge sys_clk); k = k + integrating_r; end
      chk("free", 80, k);
      capture_run <= 1'b0; trig_enable <= 1'b0; tick(45);
      tick(1); factory_reset <= 1'b1; tick(1); factory_reset <= 1'b0; k = 0;
      repeat (4) begin @(negedge sys_clk); k = k + nv_restore_r; end
      chk("restore", 1, k);
      tally_and_finish;
   end
endmodule
